// [verilog/psc_device.sv]
// Speech control end: attribute registers, modes and time base
// Operation
// - Write bus data into addressed register
// - Capture data when write select state ends
// - Host ends writes with a chip select
// - Controls apply now, targets move gradually
// - Leaving standby latches mode from dur_sel
// - dur_sel codes pick timing, pitch, request
// - Six-bit sound code selects phoneme
// - Phoneme moves at articulation rate only
// - Pitch bits immediate or transitioned by mode
// - Pitch period eight times (4096 - pitch)
// - Filter clock divides by 2(256 - div)
// - Frame timing requests each 4096(16-pace)
// - Phoneme timing multiplies frame by (4-D)
// - Transitions paced by speech pace
// - Loudness moves linearly, duration-dependent rate
// - Standby stops activity, keeps registers
// - Reset and powerdown_n force standby
// - Read drives request state, not inverted, on status line
// - Request tells host to load next data
// - clk_halve halves the master clock
// - Host loads nominal values after power-up
// - Address decode, top bit selects filter
`default_nettype none
module psc_device
  import psc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  psc_bus_if.device bus,
  input wire logic powerdown_n,
  input wire logic clk_halve,
  output logic standby,
  output logic excite_on,
  output logic pitch_pulse,
  output logic filt_clk,
  output logic [5:0] cur_sound,
  output logic [3:0] cur_loud,
  output logic [11:0] cur_pitch
);
  typedef struct packed {
    logic in_wr;
    logic [2:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] reg_dur;
    logic [7:0] reg_phi;
    logic [7:0] reg_rate;
    logic [7:0] reg_ctl;
    logic [7:0] reg_filt;
    logic stby_prev;
    logic phon_timing;
    logic trans_pitch;
    logic ack_en;
    logic req;
    logic stat;
    logic half;
    logic [15:0] pitch_cnt;
    logic pitch_pulse;
    logic [8:0] filt_cnt;
    logic filt_clk;
    logic [11:0] frame_sub;
    logic [6:0] frame_units;
    logic [13:0] art_cnt;
    logic [5:0] sound;
    logic [11:0] trans_cnt;
    logic [6:0] loud_cnt;
    logic [3:0] loud;
    logic [3:0] pstep_cnt;
    logic [4:0] pitch_hi;
  } psc_dev_state_t;

  psc_dev_state_t s;
  psc_dev_state_t n;

  // ********************************
  // Combinational next state
  // ********************************
  always_comb
  begin
    logic base;
    logic sel;
    logic wr_now;
    logic commit;
    logic dur_write;
    logic running;
    logic expiry;
    logic trans_tick;
    logic [11:0] eff;
    logic [15:0] period;
    logic [6:0] limit;
    logic [13:0] art_lim;
    logic [12:0] trans_lim;
    logic [3:0] pstep_lim;
    logic [6:0] loud_lim;
    base = 1'b0;
    sel = 1'b0;
    wr_now = 1'b0;
    commit = 1'b0;
    dur_write = 1'b0;
    running = 1'b0;
    expiry = 1'b0;
    trans_tick = 1'b0;
    eff = 12'h000;
    period = 16'h0000;
    limit = 7'h00;
    art_lim = 14'h0000;
    trans_lim = 13'h0000;
    pstep_lim = 4'h0;
    loud_lim = 7'h00;
    n = s;
    // Base tick is every cycle, or every other one when halved
    n.half = clk_halve ? ~s.half : 1'b0;
    base = clk_halve ? s.half : 1'b1;
    // Keep sampling while selected; data is valid at deselect
    sel = bus.chip_sel_hi & ~bus.chip_sel_lo_n;
    wr_now = sel & ~bus.read_not_write;
    n.in_wr = wr_now;
    if (wr_now)
    begin
      n.wr_addr = bus.reg_select;
      n.wr_data = {bus.status_bit_line, bus.data_line[6:0]};
    end
    commit = s.in_wr & ~wr_now;
    // Any way out of the write state commits, not only a select drop
    if (commit)
    begin
      if (s.wr_addr[FILT_SEL_BIT])
        n.reg_filt = s.wr_data;
      else
      begin
        unique case (s.wr_addr)
          ADDR_DUR: n.reg_dur = s.wr_data;
          ADDR_PITCH_HI: n.reg_phi = s.wr_data;
          ADDR_RATE: n.reg_rate = s.wr_data;
          ADDR_CTL: n.reg_ctl = s.wr_data;
          default: n.reg_ctl = s.reg_ctl;
        endcase
      end
    end
    dur_write = commit & (s.wr_addr == ADDR_DUR);
    // Pin powerdown wins over a software clear of standby
    if (!powerdown_n)
      n.reg_ctl[CTL_BIT] = 1'b1;
    running = ~s.reg_ctl[CTL_BIT];
    n.stby_prev = s.reg_ctl[CTL_BIT];
    // Mode latch on leaving standby; code 00 keeps timing and pitch
    if (s.stby_prev & ~s.reg_ctl[CTL_BIT])
    begin
      n.ack_en = (s.reg_dur[7:6] != 2'h0);
      unique case (s.reg_dur[7:6])
        DUR_PHON_TRANS:
        begin
          n.phon_timing = 1'b1;
          n.trans_pitch = 1'b1;
        end
        DUR_PHON_IMM:
        begin
          n.phon_timing = 1'b1;
          n.trans_pitch = 1'b0;
        end
        DUR_FRAME_IMM:
        begin
          n.phon_timing = 1'b0;
          n.trans_pitch = 1'b0;
        end
        default: n.ack_en = 1'b0;
      endcase
    end
    // Effective pitch: top and low three bits always immediate
    eff = s.trans_pitch ? {s.reg_rate[PITCH_TOP_BIT], s.pitch_hi, 3'h0, s.reg_rate[2:0]}
                        : {s.reg_rate[PITCH_TOP_BIT], s.reg_phi, s.reg_rate[2:0]};
    period = PITCH_MUL * (PITCH_SPAN - {4'h0, eff});
    n.pitch_pulse = 1'b0;
    if (running & base)
    begin
      if (s.pitch_cnt == 16'h0000)
      begin
        n.pitch_pulse = 1'b1;
        n.pitch_cnt = period - 16'h0001;
      end
      else
        n.pitch_cnt = s.pitch_cnt - 16'h0001;
      // Filter clock is independent of speech pace and pitch
      if (s.filt_cnt == 9'h000)
      begin
        n.filt_clk = ~s.filt_clk;
        n.filt_cnt = FILT_SPAN - {1'b0, s.reg_filt} - 9'h001;
      end
      else
        n.filt_cnt = s.filt_cnt - 9'h001;
    end
    // Frame and phoneme timing of data requests
    limit = PACE_SPAN - {3'h0, s.reg_rate[7:4]};
    if (s.phon_timing)
      limit = 7'(limit * (DUR_SPAN - {5'h00, s.reg_dur[7:6]}));
    if (running & base)
    begin
      n.frame_sub = s.frame_sub + 12'h001;
      if (s.frame_sub == FRAME_UNIT_LAST)
      begin
        n.frame_units = s.frame_units + 7'h01;
        if (s.frame_units + 7'h01 >= limit)
        begin
          expiry = 1'b1;
          n.frame_units = 7'h00;
        end
      end
    end
    // Request set wins over the clearing write
    if (dur_write)
      n.req = 1'b0;
    if (expiry)
      n.req = 1'b1;
    n.stat = n.req & n.ack_en & powerdown_n;
    // Articulation steps from the base clock, pace has no say
    art_lim = ART_UNIT * (ART_SPAN - {11'h000, s.reg_ctl[6:4]});
    if (running & base)
    begin
      n.art_cnt = s.art_cnt + 14'h0001;
      if (s.art_cnt + 14'h0001 >= art_lim)
      begin
        n.art_cnt = 14'h0000;
        if (s.sound < s.reg_dur[5:0])
          n.sound = s.sound + 6'h01;
        else if (s.sound > s.reg_dur[5:0])
          n.sound = s.sound - 6'h01;
      end
    end
    // Transition tick is one sixteenth of a frame; slowest pace needs a 13-bit limit
    trans_lim = {1'b0, 12'(TRANS_UNIT * {8'h00, PACE_SPAN[3:0] - s.reg_rate[7:4]})};
    if (s.reg_rate[7:4] == 4'h0)
      trans_lim = 13'({1'b0, TRANS_UNIT} * 13'h0010);
    if (running & base)
    begin
      n.trans_cnt = s.trans_cnt + 12'h001;
      if ({1'b0, s.trans_cnt} + 13'h0001 >= trans_lim)
      begin
        n.trans_cnt = 12'h000;
        trans_tick = 1'b1;
      end
    end
    // Loudness steps once per (4-D) transition ticks
    loud_lim = DUR_SPAN - {5'h00, s.reg_dur[7:6]};
    if (trans_tick)
    begin
      n.loud_cnt = s.loud_cnt + 7'h01;
      if (s.loud_cnt + 7'h01 >= loud_lim)
      begin
        n.loud_cnt = 7'h00;
        if (s.loud < s.reg_ctl[3:0])
          n.loud = s.loud + 4'h1;
        else if (s.loud > s.reg_ctl[3:0])
          n.loud = s.loud - 4'h1;
      end
    end
    // Pitch target approach, faster for a larger rate field
    pstep_lim = RATE_SPAN - {1'b0, s.reg_phi[2:0]};
    if (!s.trans_pitch)
      n.pitch_hi = s.reg_phi[7:3];
    else if (trans_tick)
    begin
      n.pstep_cnt = s.pstep_cnt + 4'h1;
      if (s.pstep_cnt + 4'h1 >= pstep_lim)
      begin
        n.pstep_cnt = 4'h0;
        if (s.pitch_hi < s.reg_phi[7:3])
          n.pitch_hi = s.pitch_hi + 5'h01;
        else if (s.pitch_hi > s.reg_phi[7:3])
          n.pitch_hi = s.pitch_hi - 5'h01;
      end
    end
    if (!rst_n)
    begin
      n = '0;
      n.reg_ctl = CTL_RESET;
      n.stby_prev = 1'b1;
    end
  end

  // ********************************
  // State register
  // ********************************
  always_ff @(posedge clock)
  begin
    s <= n;
  end

  // Status only while read-selected; the address is not looked at
  assign bus.dev_d7_oe = bus.chip_sel_hi & ~bus.chip_sel_lo_n & bus.read_not_write;
  assign bus.dev_d7 = s.stat;
  assign bus.ack_oe = s.stat;
  assign standby = s.reg_ctl[CTL_BIT];
  assign excite_on = ~s.stby_prev;
  assign pitch_pulse = s.pitch_pulse;
  assign filt_clk = s.filt_clk;
  assign cur_sound = s.sound;
  assign cur_loud = s.loud;
  assign cur_pitch = s.trans_pitch ? {s.reg_rate[PITCH_TOP_BIT], s.pitch_hi, 3'h0, s.reg_rate[2:0]}
                                   : {s.reg_rate[PITCH_TOP_BIT], s.reg_phi, s.reg_rate[2:0]};
endmodule
`default_nettype wire

// [pkg/psc_pkg.sv]
// Shared constants for the phoneme speech control ends
`default_nettype none
package psc_pkg;
  // ********************************
  // Clock and bus timing
  // ********************************
  localparam int CLK_MHZ = 20;
  localparam int STROBE_NS = 200;
  localparam int HOLD_NS = 10;
  localparam int CYCLE_NS = 2250;
  localparam int ACCESS_NS = 180;
  // Least times round up to whole cycles
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int CYCLE_CYC = (CYCLE_NS * CLK_MHZ + 999) / 1000;
  localparam int ACCESS_CYC = (ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int GAP_CYC = CYCLE_CYC - STROBE_CYC - HOLD_CYC;
  // ********************************
  // Register addresses and fields
  // ********************************
  localparam logic [2:0] ADDR_DUR = 3'h0;
  localparam logic [2:0] ADDR_PITCH_HI = 3'h1;
  localparam logic [2:0] ADDR_RATE = 3'h2;
  localparam logic [2:0] ADDR_CTL = 3'h3;
  localparam int FILT_SEL_BIT = 2;
  localparam int CTL_BIT = 7;
  localparam int PITCH_TOP_BIT = 3;
  localparam logic [7:0] CTL_RESET = 8'h80;
  localparam logic [7:0] NOMINAL_RATE = 8'hA0;
  localparam logic [7:0] NOMINAL_CTL = 8'hDC;
  // ********************************
  // Mode codes of dur_sel
  // ********************************
  localparam logic [1:0] DUR_PHON_TRANS = 2'h3;
  localparam logic [1:0] DUR_PHON_IMM = 2'h2;
  localparam logic [1:0] DUR_FRAME_IMM = 2'h1;
  // ********************************
  // Time base divisors, in base ticks
  // ********************************
  localparam logic [15:0] PITCH_MUL = 16'h0008;
  localparam logic [15:0] PITCH_SPAN = 16'h1000;
  localparam logic [8:0] FILT_SPAN = 9'h100;
  localparam logic [11:0] FRAME_UNIT_LAST = 12'hFFF;
  localparam logic [6:0] PACE_SPAN = 7'h10;
  localparam logic [6:0] DUR_SPAN = 7'h04;
  localparam logic [13:0] ART_UNIT = 14'h0400;
  localparam logic [13:0] ART_SPAN = 14'h0008;
  localparam logic [11:0] TRANS_UNIT = 12'h100;
  localparam logic [3:0] RATE_SPAN = 4'h8;
endpackage
`default_nettype wire

// [pkg/psc_bus_if.sv]
// Parallel attribute bus joining the microprocessor end and the speech end
`default_nettype none
interface psc_bus_if;
  logic [2:0] reg_select;
  logic read_not_write;
  logic chip_sel_hi;
  logic chip_sel_lo_n;
  logic [7:0] host_data;
  logic host_data_oe;
  logic dev_d7;
  logic dev_d7_oe;
  logic ack_oe;
  logic [7:0] data_line;
  logic status_bit_line;
  logic ack_req_n;
  // Wire resolution: undriven lines pull high, the open-collector line too
  assign data_line = host_data_oe ? host_data : 8'hFF;
  assign status_bit_line = dev_d7_oe ? dev_d7 : data_line[7];
  assign ack_req_n = ~ack_oe;
  modport device (
    input reg_select, read_not_write, chip_sel_hi, chip_sel_lo_n, data_line, status_bit_line,
    output dev_d7, dev_d7_oe, ack_oe
  );
  modport host (
    output reg_select, read_not_write, chip_sel_hi, chip_sel_lo_n, host_data, host_data_oe,
    input status_bit_line, ack_req_n
  );
endinterface
`default_nettype wire

// [verilog/psc_host.sv]
// Microprocessor end: paced register writes and status reads
`default_nettype none
module psc_host
  import psc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  psc_bus_if.host bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic [2:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  output logic rd_valid,
  output logic rd_status,
  output logic data_req
);
  typedef enum logic [1:0] {
    PSC_IDLE = 2'b00,
    PSC_STROBE = 2'b01,
    PSC_HOLD = 2'b11,
    PSC_GAP = 2'b10
  } psc_host_st_t;

  typedef struct packed {
    psc_host_st_t st;
    logic [5:0] cnt;
    logic rnw;
    logic sel;
    logic [2:0] addr;
    logic [7:0] data;
    logic data_oe;
    logic [1:0] init;
    logic rd_valid;
    logic rd_status;
  } psc_host_state_t;

  psc_host_state_t s;
  psc_host_state_t n;

  // ********************************
  // Bus cycle sequencer
  // ********************************
  always_comb
  begin
    n = s;
    n.rd_valid = 1'b0;
    n.cnt = s.cnt + 6'h01;
    unique case (s.st)
      PSC_IDLE:
      begin
        n.cnt = 6'h00;
        // Nominal pace and loudness first, standby left set
        if (s.init != 2'h2)
        begin
          n.st = PSC_STROBE;
          n.rnw = 1'b0;
          n.sel = 1'b1;
          n.data_oe = 1'b1;
          n.addr = (s.init == 2'h0) ? ADDR_RATE : ADDR_CTL;
          n.data = (s.init == 2'h0) ? NOMINAL_RATE : NOMINAL_CTL;
          n.init = s.init + 2'h1;
        end
        else if (cmd_valid)
        begin
          n.st = PSC_STROBE;
          n.rnw = cmd_read;
          n.sel = 1'b1;
          n.data_oe = ~cmd_read;
          n.addr = cmd_addr;
          n.data = cmd_data;
        end
      end
      PSC_STROBE:
      begin
        // Strobe width covers the status access time as well
        if (s.cnt == 6'(STROBE_CYC - 1))
        begin
          n.st = PSC_HOLD;
          n.cnt = 6'h00;
          n.sel = 1'b0;
          n.rd_valid = s.rnw;
          n.rd_status = s.rnw ? bus.status_bit_line : s.rd_status;
        end
      end
      PSC_HOLD:
      begin
        // Data held past deselect, read_not_write left steady
        if (s.cnt == 6'(HOLD_CYC - 1))
        begin
          n.st = PSC_GAP;
          n.cnt = 6'h00;
          n.data_oe = 1'b0;
        end
      end
      PSC_GAP:
      begin
        if (s.cnt == 6'(GAP_CYC - 1))
        begin
          n.st = PSC_IDLE;
          n.cnt = 6'h00;
        end
      end
    endcase
    if (!rst_n)
    begin
      n = '0;
      n.st = PSC_IDLE;
      n.rnw = 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    s <= n;
  end

  assign cmd_ready = (s.st == PSC_IDLE) & (s.init == 2'h2);
  assign rd_valid = s.rd_valid;
  assign rd_status = s.rd_status;
  assign data_req = ~bus.ack_req_n;
  assign bus.read_not_write = s.rnw;
  assign bus.chip_sel_hi = s.sel;
  assign bus.chip_sel_lo_n = ~s.sel;
  assign bus.reg_select = s.addr;
  assign bus.host_data = s.data;
  assign bus.host_data_oe = s.data_oe;
endmodule
`default_nettype wire

// [bench/psc_bus_sva.sv]
// Protocol checker watching the attribute bus between the two ends
`default_nettype none
module psc_bus_sva
  import psc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [2:0] reg_select,
  input wire logic read_not_write,
  input wire logic chip_sel_hi,
  input wire logic chip_sel_lo_n,
  input wire logic [7:0] data_line,
  input wire logic host_data_oe,
  input wire logic dev_d7_oe,
  input wire logic status_bit_line,
  input wire logic ack_req_n
);
  // ********************************
  // Decoded bus states
  // ********************************
  logic sel_any;
  logic sel_wr;
  logic sel_rd;
  logic [6:0] gap_cnt;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Select states seen on the wire
  assign sel_any = chip_sel_hi && !chip_sel_lo_n;
  assign sel_wr = sel_any && !read_not_write;
  assign sel_rd = sel_any && read_not_write;
  // Idle cycles since last select; saturates so long pauses never wrap
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      gap_cnt <= 7'h7F;
    else if (sel_any)
      gap_cnt <= 7'h00;
    else if (gap_cnt != 7'h7F)
      gap_cnt <= gap_cnt + 7'h01;
  end
  // ********************************
  // Assertions
  // ********************************
  sequence s_write_end;
    sel_wr ##1 !sel_wr;
  endsequence
  sequence s_dur_write;
    (sel_wr && reg_select == ADDR_DUR) ##1 !sel_wr;
  endsequence
  sequence s_read_held;
    sel_rd ##1 sel_rd;
  endsequence
  a_read_drives_d7: assert property (sel_rd |-> dev_d7_oe)
    else $error("status line not driven in read");
  a_d7_quiet: assert property (!sel_rd |-> !dev_d7_oe)
    else $error("status line driven outside read");
  a_status_mirror: assert property (s_read_held |-> status_bit_line == !ack_req_n)
    else $error("status line differs from request");
  a_write_held: assert property (sel_wr && $past(sel_wr) |-> $stable(data_line) && $stable(reg_select))
    else $error("data or address moved in write");
  a_strobe_width: assert property ($rose(sel_wr) |-> sel_wr [*4])
    else $error("write strobe too short");
  a_end_by_select: assert property (s_write_end |-> !sel_any)
    else $error("write not ended by a chip select");
  a_data_hold: assert property (s_write_end |-> host_data_oe)
    else $error("data released before hold time");
  a_cycle_gap: assert property ($rose(sel_any) |-> gap_cnt >= GAP_CYC)
    else $error("bus cycles too close");
  a_ack_release: assert property (s_dur_write |-> ##[0:2] ack_req_n)
    else $error("request not released by phoneme write");
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// Self-checking bench joining the host end and the speech end
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin mismatches++; \
  $display("Error at %0t: got %0h expected %0h", $time, got, exp); end end
module tb_top
  import psc_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock;
  logic rst_n;
  logic powerdown_n;
  logic clk_halve;
  logic cmd_valid;
  logic cmd_read;
  logic [2:0] cmd_addr;
  logic [7:0] cmd_data;
  logic cmd_ready;
  logic rd_valid;
  logic rd_status;
  logic data_req;
  logic standby;
  logic excite_on;
  logic pitch_pulse;
  logic filt_clk;
  logic [5:0] cur_sound;
  logic [3:0] cur_loud;
  logic [11:0] cur_pitch;
  int mismatches = 0;
  int checked = 0;
  int cyc = 0;
  psc_bus_if psc_bus_if_inst ();
  psc_device psc_device_inst (.clock(clock), .rst_n(rst_n), .bus(psc_bus_if_inst.device),
    .powerdown_n(powerdown_n), .clk_halve(clk_halve), .standby(standby), .excite_on(excite_on),
    .pitch_pulse(pitch_pulse), .filt_clk(filt_clk), .cur_sound(cur_sound), .cur_loud(cur_loud),
    .cur_pitch(cur_pitch));
  psc_host psc_host_inst (.clock(clock), .rst_n(rst_n), .bus(psc_bus_if_inst.host),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .rd_valid(rd_valid), .rd_status(rd_status), .data_req(data_req));
  psc_bus_sva psc_bus_sva_inst (.clock(clock), .rst_n(rst_n),
    .reg_select(psc_bus_if_inst.reg_select), .read_not_write(psc_bus_if_inst.read_not_write),
    .chip_sel_hi(psc_bus_if_inst.chip_sel_hi), .chip_sel_lo_n(psc_bus_if_inst.chip_sel_lo_n),
    .data_line(psc_bus_if_inst.data_line), .host_data_oe(psc_bus_if_inst.host_data_oe),
    .dev_d7_oe(psc_bus_if_inst.dev_d7_oe), .status_bit_line(psc_bus_if_inst.status_bit_line),
    .ack_req_n(psc_bus_if_inst.ack_req_n));
  // ********************************
  // Clock and helpers
  // ********************************
  // 50 ns clock and a free cycle count for interval measurement
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) cyc <= cyc + 1;
  task automatic final_report();
    if (mismatches == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // A hang counts against the run and closes it at once
  task automatic fail_out();
    mismatches++;
    final_report();
  endtask
  function automatic logic sig(input int which);
    return which == 0 ? filt_clk : (which == 1 ? pitch_pulse : data_req);
  endfunction
  // Low then high must be seen, so a level left over never counts as a rise
  task automatic wait_rise(input int which, output int t);
    int n;
    bit low;
    low = 0;
    for (n = 0; n < 50000; n++)
    begin
      @(negedge clock);
      if (low && sig(which) === 1'b1)
        break;
      low = low || sig(which) === 1'b0;
    end
    t = cyc;
    if (n == 50000)
      fail_out();
  endtask
  // Request held from a falling edge until a rising edge sees ready
  task automatic bus_op(input logic rd, input logic [2:0] a, input logic [7:0] d);
    int n;
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_addr = a;
    cmd_data = d;
    for (n = 0; n < 200 && cmd_ready !== 1'b1; n++)
      @(negedge clock);
    if (n == 200)
      fail_out();
    @(negedge clock);
    cmd_valid = 1'b0;
  endtask
  task automatic read_status(input logic exp);
    int n;
    bus_op(1'b1, 3'($urandom_range(7)), 8'h00);
    for (n = 0; n < 10 && rd_valid !== 1'b1; n++)
      @(negedge clock);
    if (n == 10)
      fail_out();
    `CHK(rd_status, exp)
  endtask
  // ********************************
  // Main sequence
  // ********************************
  initial
  begin
    int seed;
    int p;
    int t0;
    int t1;
    logic [7:0] hi;
    logic [7:0] ff;
    rst_n = 1'b0;
    powerdown_n = 1'b1;
    clk_halve = 1'b0;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_addr = 3'h0;
    cmd_data = 8'h00;
    seed = $urandom(32);
    hi = 8'hF0 | 8'($urandom_range(15));
    ff = 8'hF0 | 8'($urandom_range(15));
    repeat (12) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    `CHK(standby, 1'b1)
    bus_op(1'b0, ADDR_RATE, 8'hFF);
    `CHK(standby, 1'b1)
    bus_op(1'b0, ADDR_PITCH_HI, hi);
    bus_op(1'b0, 3'h4 | 3'($urandom_range(3)), ff);
    bus_op(1'b0, ADDR_DUR, {DUR_FRAME_IMM, 6'h03});
    bus_op(1'b0, ADDR_CTL, 8'h7C);
    repeat (8) @(negedge clock);
    `CHK(standby, 1'b0)
    `CHK(excite_on, 1'b1)
    p = {1'b1, hi, 3'h7};
    `CHK(cur_pitch, 12'(p))
    wait_rise(1, t0);
    wait_rise(1, t1);
    `CHK(t1 - t0, 8 * (4096 - p))
    // Filter clock at both base rates; period doubles when halved
    for (int h = 0; h < 2; h++)
    begin
      clk_halve = h[0];
      wait_rise(0, t0);
      wait_rise(0, t1);
      `CHK(t1 - t0, 2 * (256 - ff) * (h + 1))
    end
    clk_halve = 1'b0;
    powerdown_n = 1'b0;
    repeat (3) @(negedge clock);
    `CHK(standby, 1'b1)
    `CHK(excite_on, 1'b0)
    powerdown_n = 1'b1;
    `CHK(cur_pitch, 12'(p))
    bus_op(1'b0, ADDR_CTL, 8'h7C);
    repeat (10000) @(negedge clock);
    `CHK(cur_sound, 6'h03)
    `CHK(cur_loud, 4'hC)
    bus_op(1'b0, ADDR_DUR, {DUR_FRAME_IMM, 6'h05});
    repeat (7) @(negedge clock);
    `CHK(cur_sound, 6'h03)
    repeat (3000) @(negedge clock);
    `CHK(cur_sound, 6'h05)
    // Each timing mode latched on leaving standby, then request spacing
    for (int m = 1; m < 4; m++)
    begin
      bus_op(1'b0, ADDR_CTL, 8'hFC);
      bus_op(1'b0, ADDR_DUR, {m[1:0], 6'h05});
      bus_op(1'b0, ADDR_CTL, 8'h7C);
      wait_rise(2, t0);
      read_status(1'b1);
      bus_op(1'b0, ADDR_DUR, {m[1:0], 6'h05});
      repeat (8) @(negedge clock);
      `CHK(data_req, 1'b0)
      read_status(1'b0);
      wait_rise(2, t1);
      `CHK(t1 - t0, 4096 * (16 - 15) * (m == 1 ? 1 : 4 - m))
    end
    // Code 00 silences the request line; kept timing is four frames
    bus_op(1'b0, ADDR_CTL, 8'hFC);
    bus_op(1'b0, ADDR_DUR, 8'h05);
    bus_op(1'b0, ADDR_CTL, 8'h7C);
    repeat (17000) @(negedge clock);
    `CHK(data_req, 1'b0)
    final_report();
  end
endmodule
`default_nettype wire
